/* dram_lane_model.sv */
// memory word model: keeps one stored word behind the lane masks
`timescale 1ns/100ps
module dram_lane_model(input wire clk, input wire [1:0] dram_bank_select_n, input wire dram_column_strobe_n,
   dram_write_strobe_n, input wire [3:0] byte_lane_mask, input wire [31:0] wr_word,
   output reg [31:0] stored_word = 32'h00000000);
   integer i;
   // a write keeps every lane whose mask is high
   always @(posedge clk) for (i = 0; i < 4; i = i + 1)
      if (~&dram_bank_select_n & ~dram_column_strobe_n & ~dram_write_strobe_n & ~byte_lane_mask[i])
         stored_word[8*i+:8] <= wr_word[8*i+:8];
endmodule // dram_lane_model

/* lane_merge.v */
// byte lane merge: masked write into a stored word, masked read enables
`timescale 1ns/100ps
`include "strobe_regs.vh"
module lane_merge (
   input  wire [3:0]  mask,
   input  wire [31:0] old_word,
   input  wire [31:0] new_word,
   output wire [31:0] merged,
   output wire [31:0] read_en
);
   genvar i;
   // lane i covers bits 8i+7:8i; mask high keeps the old byte
   generate
      for (i = 0; i < `LANES; i = i + 1) begin : g_lane
         assign merged[i*8+7:i*8]  = mask[i] ? old_word[i*8+7:i*8] : new_word[i*8+7:i*8];
         assign read_en[i*8+7:i*8] = {8{~mask[i]}};
      end
   endgenerate
endmodule // lane_merge

/* sdram_io_bank_strobes.v */
// memory strobe, bank select and byte lane mask outputs
`timescale 1ns/100ps
`include "strobe_regs.vh"
module sdram_io_bank_strobes (
   input  wire        clk,
   input  wire        rst,
   input  wire        ce,
   input  wire        dram_req,
   input  wire        dram_bank,
   input  wire [2:0]  dram_cmd,
   input  wire        io_req,
   input  wire [1:0]  io_bank,
   input  wire [13:0] io_addr,
   input  wire [3:0]  lane_keep,
   input  wire [31:0] wr_word,
   input  wire [31:0] stored_word,
   output reg  [1:0]  dram_bank_select_n,
   output reg         dram_row_strobe_n,
   output reg         dram_column_strobe_n,
   output reg         dram_write_strobe_n,
   output reg  [3:0]  byte_lane_mask,
   output reg  [2:0]  io_bank_select_n,
   output reg  [13:0] io_addr_out,
   output reg  [31:0] merged_word_r,
   output reg  [31:0] read_en_r,
   output reg         io_err_r
);
   // the user sequences dram commands; this block only steers them onto the pins
   // limitation: no refresh or timing checks here, a raw command passes as given
   // no control registers: every choice arrives on an input in each cycle, only the outputs are flops
   // ce low holds every flop, so a stalled access keeps its selects and strobes

   // timing, with ce high at every edge:
   //   edge n   samples the request, bank number, command and lane mask
   //   after n  selects, strobes and masks show that request on the pins
   //   edge n+1 takes the next request; back-to-back accesses need no gap
   // with ce low an edge changes nothing, the pins keep the last access
   // reset is asynchronous and parks the pins at their idle levels:
   //   all selects and strobes high, every lane masked, words cleared
   // priority: a dram request hides an io request made in the same cycle,
   //   which is what keeps at most one of the five selects low
   // hazard: stored_word comes from the memory side and must be settled
   //   before the edge, the merge is combinational up to merged_word_r

   // sizes of the io bank group and the lane set
   // 16KB per io bank is covered by the 14-bit offset
   localparam IO_SELS  = `IO_BANKS;
   localparam LANE_CNT = `LANES;

   // datapath results of the lane merge, the next lane mask and the grant
   wire [31:0] merged;
   wire [31:0] read_en;
   wire [3:0]  mask_nxt;
   wire        any_grant;

   // grants and next values of the registered outputs
   reg         dram_grant;
   reg         io_grant;
   reg  [2:0]  dsel_wide;
   reg  [1:0]  dsel_nxt;
   reg  [2:0]  iosel_nxt;
   reg  [2:0]  cmd_nxt;
   reg         err_nxt;

   genvar      l;

   // one-hot active-low decode, shared by both bank groups
   function [2:0] sel_low;
      input [1:0] idx;
      begin
         case (idx)
            2'h0:    sel_low = 3'h6;
            2'h1:    sel_low = 3'h5;
            2'h2:    sel_low = 3'h3;
            default: sel_low = 3'h7;
         endcase
      end
   endfunction

   // bank 3 of the io group has no select pin
   // shared by the select decode and the error decode
   function io_mapped;
      input [1:0] idx;
      begin
         io_mapped = ({30'h0, idx} < IO_SELS);
      end
   endfunction

   // byte lane merge and read enables, one generate slice per lane
   // the memory side feeds stored_word back, so the merge shows what a masked write leaves
   lane_merge u_merge (
      .mask     (lane_keep),
      .old_word (stored_word),
      .new_word (wr_word),
      .merged   (merged),
      .read_en  (read_en)
   );

   // dram wins when both ask, so a single select can fall in any cycle
   // io_req waits while dram_req stands; it is not queued
   always @* begin
      dram_grant = dram_req;
      io_grant   = 1'b0;
      if (!dram_req && io_req) begin
         io_grant = 1'b1;
      end
   end

   // either group granted; the masks open only then
   assign any_grant = dram_grant | io_grant;

   // bank selects: only the granted group decodes its bank number
   // dsel_wide is the 3-bit decode, cut down to the two dram pins
   always @* begin
      dsel_wide = sel_low({1'b0, dram_bank});
      dsel_nxt  = `RST_DRAM_SEL;
      iosel_nxt = `RST_IO_SEL;
      if (dram_grant) begin
         dsel_nxt = dsel_wide[1:0];
      end
      if (io_grant && io_mapped(io_bank)) begin
         iosel_nxt = sel_low(io_bank);
      end
   end

   // an access to the unmapped io bank raises the error flag for that cycle only
   // nothing is latched, so no clear is needed
   always @* begin
      err_nxt = 1'b0;
      if (io_grant && !io_mapped(io_bank)) begin
         err_nxt = 1'b1;
      end
   end

   // command levels pass through raw; a nop keeps all three strobes high
   // bit 2 row, bit 1 column, bit 0 write
   always @* begin
      cmd_nxt = `CMD_NOP;
      if (dram_grant) begin
         cmd_nxt = dram_cmd;
      end
   end

   // a lane is masked outside any access so an idle bus never drives read data
   generate
      for (l = 0; l < LANE_CNT; l = l + 1) begin : g_mask
         assign mask_nxt[l] = any_grant ? lane_keep[l] : 1'b1;
      end
   endgenerate

   // dram bank selects; both high outside a dram access
   // bank 0 pulls bit 0 low, bank 1 bit 1
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         dram_bank_select_n <= `RST_DRAM_SEL;
      end else if (ce) begin
         dram_bank_select_n <= dsel_nxt;
      end
   end

   // row, column and write strobes follow the command bits one cycle later
   // they share one command word, so they never disagree within a cycle
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         {dram_row_strobe_n, dram_column_strobe_n, dram_write_strobe_n} <= `RST_STROBES;
      end else if (ce) begin
         dram_row_strobe_n    <= cmd_nxt[2];
         dram_column_strobe_n <= cmd_nxt[1];
         dram_write_strobe_n  <= cmd_nxt[0];
      end
   end

   // lane masks; reset leaves every lane masked
   // a write masks stored bytes, a read masks driven bytes; the pin is the same
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         byte_lane_mask <= `RST_MASK;
      end else if (ce) begin
         byte_lane_mask <= mask_nxt;
      end
   end

   // io bank selects and the unmapped-bank flag move together
   // bank 0 pulls bit 0 low, up to bank 2 on bit 2
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         io_bank_select_n <= `RST_IO_SEL;
         io_err_r         <= `RST_ERR;
      end else if (ce) begin
         io_bank_select_n <= iosel_nxt;
         io_err_r         <= err_nxt;
      end
   end

   // io offset; 14 bits bound each io bank to 16KB
   // the offset passes even without an io access, the selects alone qualify it
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         io_addr_out <= `RST_ADDR;
      end else if (ce) begin
         io_addr_out <= io_addr;
      end
   end

   // merged word and read enables, registered so the outputs come from flops
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         merged_word_r <= `RST_WORD;
         read_en_r     <= `RST_WORD;
      end else if (ce) begin
         merged_word_r <= merged;
         read_en_r     <= read_en;
      end
   end
endmodule // sdram_io_bank_strobes

/* sdram_io_bank_strobes_bench.sv */
// self-checking bench for the strobe and select block
`timescale 1ns/100ps
module sdram_io_bank_strobes_bench;
   reg clk = 0, rst = 1, ce = 1, dram_req = 0, dram_bank = 0, io_req = 0;
   reg [2:0] dram_cmd = 3'h7;
   reg [1:0] io_bank = 0;
   reg [13:0] io_addr = 0;
   reg [3:0] lane_keep = 0;
   reg [31:0] wr_word = 0;
   wire [31:0] stored_word, merged_word_r, read_en_r;
   wire [1:0] dram_bank_select_n;
   wire [3:0] byte_lane_mask;
   wire [2:0] io_bank_select_n;
   wire [13:0] io_addr_out;
   wire dram_row_strobe_n, dram_column_strobe_n, dram_write_strobe_n, io_err_r;
   integer n_fail = 0, compares = 0, i;
   always #50 clk = ~clk;
   sdram_io_bank_strobes i_dut(.clk(clk), .rst(rst), .ce(ce), .dram_req(dram_req), .dram_bank(dram_bank),
      .dram_cmd(dram_cmd), .io_req(io_req), .io_bank(io_bank), .io_addr(io_addr), .lane_keep(lane_keep),
      .wr_word(wr_word), .stored_word(stored_word), .dram_bank_select_n(dram_bank_select_n),
      .dram_row_strobe_n(dram_row_strobe_n), .dram_column_strobe_n(dram_column_strobe_n),
      .dram_write_strobe_n(dram_write_strobe_n), .byte_lane_mask(byte_lane_mask),
      .io_bank_select_n(io_bank_select_n), .io_addr_out(io_addr_out), .merged_word_r(merged_word_r),
      .read_en_r(read_en_r), .io_err_r(io_err_r));
   dram_lane_model i_mem(.clk(clk), .dram_bank_select_n(dram_bank_select_n),
      .dram_column_strobe_n(dram_column_strobe_n), .dram_write_strobe_n(dram_write_strobe_n),
      .byte_lane_mask(byte_lane_mask), .wr_word(wr_word), .stored_word(stored_word));
   task cmp(input [31:0] g, e); begin
      compares = compares + 1;
      if (g !== e) begin n_fail = n_fail + 1; $display("[FAIL] %0t got %h want %h", $time, g, e); end
   end endtask
   // inputs move 10 ns after the edge, outputs are read after the next one
   task step; begin @(posedge clk); #10; end endtask
   task s_dram; begin // every command code, banks alternating, io request overruled
      for (i = 0; i < 8; i = i + 1) begin
         dram_req = 1; dram_bank = i[0]; dram_cmd = i[2:0]; lane_keep = ~i[3:0]; io_req = 1; io_bank = i[1:0]; step;
         cmp({dram_bank_select_n, dram_row_strobe_n, dram_column_strobe_n, dram_write_strobe_n, byte_lane_mask},
            {~(2'h1 << i[0]), i[2:0], ~i[3:0]});
         cmp({io_bank_select_n, io_err_r}, 4'he);
      end
      dram_req = 0;
   end endtask
   task s_io; begin // all io banks back to back, bank 3 unmapped
      for (i = 0; i < 4; i = i + 1) begin
         io_bank = i[1:0]; io_addr = 14'h3fff - i[13:0]; step;
         cmp({io_bank_select_n, io_err_r, dram_bank_select_n, io_addr_out},
            {~(3'h1 << i[1:0]), i == 3, 2'h3, 14'h3fff - i[13:0]});
      end
      io_req = 0;
   end endtask
   task s_lane; begin // write of lanes 1 and 3, lanes 0 and 2 masked
      dram_req = 1; dram_bank = 0; dram_cmd = 3'h4; lane_keep = 4'h5; wr_word = 32'h44332211; step;
      cmp(merged_word_r, 32'h44002200);
      cmp(read_en_r, 32'hff00ff00);
      dram_req = 0; step;
      cmp(stored_word, 32'h44002200);
   end endtask
   task s_hold; begin // ce low freezes the pins, then a reset in mid-run parks them
      dram_req = 1; dram_bank = 1; dram_cmd = 3'h3; lane_keep = 4'h6; step;
      ce = 0; dram_req = 0; io_req = 1; io_bank = 2'h1; lane_keep = 4'h9; step;
      cmp({dram_bank_select_n, dram_row_strobe_n, dram_column_strobe_n, dram_write_strobe_n, byte_lane_mask,
         io_bank_select_n}, {2'h1, 3'h3, 4'h6, 3'h7});
      ce = 1; step;
      cmp({dram_bank_select_n, io_bank_select_n, byte_lane_mask}, {2'h3, 3'h5, 4'h9});
      io_req = 0; step;
      cmp({dram_bank_select_n, dram_row_strobe_n, dram_column_strobe_n, dram_write_strobe_n, byte_lane_mask,
         io_bank_select_n}, {2'h3, 3'h7, 4'hf, 3'h7});
      dram_req = 1; io_addr = 14'h1234; step; rst = 1; step;
      cmp({dram_bank_select_n, dram_row_strobe_n, dram_column_strobe_n, dram_write_strobe_n, byte_lane_mask,
         io_bank_select_n, io_err_r, io_addr_out}, {2'h3, 3'h7, 4'hf, 3'h7, 1'b0, 14'h0000});
      cmp(merged_word_r, 32'h00000000);
      cmp(read_en_r, 32'h00000000);
      rst = 0; dram_req = 0; step;
      cmp(io_addr_out, 14'h1234);
   end endtask
   task summarize; begin
      $display("n_fail %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   end endtask
   initial begin #20000; n_fail = n_fail + 1; summarize; end
   initial begin repeat (4) @(posedge clk); #10 rst = 0; s_dram; s_io; s_lane; s_hold; summarize; end
endmodule // sdram_io_bank_strobes_bench

/* strobe_chk.sv */
// assertions on the strobe, select and lane mask outputs
`timescale 1ns/100ps
module strobe_chk(input wire clk, rst, ce, dram_req, dram_bank, io_req, input wire [2:0] dram_cmd,
   input wire [1:0] io_bank, input wire [3:0] lane_keep, byte_lane_mask, input wire [31:0] wr_word, stored_word,
   merged_word_r, read_en_r, input wire [1:0] dram_bank_select_n, input wire dram_row_strobe_n,
   dram_column_strobe_n, dram_write_strobe_n, input wire [2:0] io_bank_select_n);
   // t marks an edge that really updates, so reset edges never arm a check
   wire t = ce & ~rst;
   wire d = t & dram_req;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   bank_sel_a: assert property ($past(d) |-> dram_bank_select_n == ~(2'h1 << $past(dram_bank))) else $error("sel");
   strobe_cmd_a: assert property ($past(d) |->
      {dram_row_strobe_n, dram_column_strobe_n, dram_write_strobe_n} == $past(dram_cmd)) else $error("cmd");
   idle_high_a: assert property ($past(t & ~dram_req) |-> &{dram_row_strobe_n, dram_column_strobe_n,
      dram_write_strobe_n, dram_bank_select_n}) else $error("idle");
   lane_mask_a: assert property ($past(d) |-> byte_lane_mask == $past(lane_keep)) else $error("mask");
   read_en_a: assert property ($past(d) |-> read_en_r[7:0] == {8{~$past(lane_keep[0])}}) else $error("ren");
   merge_top_a: assert property ($past(d) |-> merged_word_r[31:24] ==
      ($past(lane_keep[3]) ? $past(stored_word[31:24]) : $past(wr_word[31:24]))) else $error("merge");
   io_sel_a: assert property ($past(t & io_req & ~dram_req & ~&io_bank) |->
      io_bank_select_n == ~(3'h1 << $past(io_bank))) else $error("io");
   one_sel_a: assert property ($countones({dram_bank_select_n, io_bank_select_n}) >= 4) else $error("two");
endmodule // strobe_chk
bind sdram_io_bank_strobes strobe_chk i_chk(.clk(clk), .rst(rst), .ce(ce), .dram_req(dram_req),
   .dram_bank(dram_bank), .io_req(io_req), .dram_cmd(dram_cmd), .io_bank(io_bank), .lane_keep(lane_keep),
   .byte_lane_mask(byte_lane_mask), .wr_word(wr_word), .stored_word(stored_word), .merged_word_r(merged_word_r),
   .read_en_r(read_en_r), .dram_bank_select_n(dram_bank_select_n), .dram_row_strobe_n(dram_row_strobe_n),
   .dram_column_strobe_n(dram_column_strobe_n), .dram_write_strobe_n(dram_write_strobe_n),
   .io_bank_select_n(io_bank_select_n));

/* strobe_regs.vh */
// constants for the memory strobe and select block
`ifndef STROBE_REGS_VH
`define STROBE_REGS_VH
`define DRAM_BANKS        2
`define IO_BANKS          3
`define LANES             4
`define LANE_BITS         8
`define IO_BANK_BYTES     16384
`define IO_ADDR_BITS      14
`define CMD_NOP           3'h7
`define CMD_ACTIVE        3'h3
`define CMD_READ          3'h5
`define CMD_WRITE         3'h4
`define CMD_PRECHARGE     3'h2
`define CMD_REFRESH       3'h1
`define CMD_MODE          3'h0
`define RST_STROBES       3'h7
`define RST_MASK          4'hf
`define RST_DRAM_SEL      2'h3
`define RST_IO_SEL        3'h7
`define RST_ADDR          14'h0000
`define RST_WORD          32'h00000000
`define RST_ERR           1'b0
`endif
